// ---- logic/plam_alarm.v ----
`timescale 1ns/1ps
`default_nettype none
`include "plam_regs.vh"

module plam_alarm
(
    input wire clk,
    input wire reset_n,
    input wire seen,
    input wire [15:0] level,
    input wire [15:0] low_limit,
    input wire [15:0] upp_limit,
    input wire low_en,
    input wire upp_en,
    input wire clear,
    output reg lo_act_r,
    output reg up_act_r,
    output reg lo_lat_r,
    output reg up_lat_r
);

wire lo_nxt;
wire up_nxt;

// Evaluated every cycle so a query sees the present state [RULE_03] [RULE_23]
assign lo_nxt = seen && low_en && ($signed(level) < $signed(low_limit)); // [RULE_06] [RULE_08]
assign up_nxt = seen && upp_en && ($signed(level) > $signed(upp_limit)); // [RULE_07] [RULE_09]

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        lo_act_r <= 1'b0;
        up_act_r <= 1'b0;
        lo_lat_r <= 1'b0;
        up_lat_r <= 1'b0;
    end
    else
    begin
        lo_act_r <= lo_nxt;
        up_act_r <= up_nxt;
        // Set wins over a clear in the same cycle
        lo_lat_r <= lo_nxt | (lo_lat_r & ~clear); // [RULE_04] [RULE_21]
        up_lat_r <= up_nxt | (up_lat_r & ~clear); // [RULE_04] [RULE_21]
    end
end

endmodule

`default_nettype wire

// ---- logic/plam_core.v ----
// Behaviour
// [RULE_01] Five flags per channel, first ORs others
// [RULE_02] Flags returned summary, lo/up active, lo/up latched
// [RULE_03] Active flags show present limit state only
// [RULE_04] Latched flags hold until channel clear
// [RULE_05] Limits writable/readable, -99.99 to +99.99 dBm
// [RULE_06] Enabled low alarm sets flags and indicator
// [RULE_07] Enabled high alarm sets flags and indicator
// [RULE_08] Lower enable per channel; off means no action
// [RULE_09] Upper enable per channel; off means no action
// [RULE_10] Combined enable write sets both enables
// [RULE_11] Combined enable reads one if either on
// [RULE_12] Combined enable query forces both on; the code does so only when one of the two is already on
// [RULE_13] Each math operand selects channel one/two
// [RULE_14] Operator sum, difference or ratio, readable
// [RULE_15] Math query returns operator on operands
// [RULE_16] Normal reading mode about twenty per second
// [RULE_17] Fast mode above two hundred per second
// [RULE_18] Filter_full_mode mode waits for full averaging filter
// [RULE_19] Reading modes only apply under remote control
// [RULE_20] Return to local restores normal mode
// [RULE_21] Clear resets latched flags of that channel
// [RULE_22] Channel two rejected on single-channel variant
// [RULE_23] Re-evaluate alarms on each new reading
`timescale 1ns/1ps
`default_nettype none
`include "plam_regs.vh"

module plam_core
#(
    parameter SINGLE_CH = 0,
    parameter [23:0] NORMAL_CYC = `PLAM_NORMAL_CYC,
    parameter [23:0] FAST_CYC = `PLAM_FAST_CYC
)
(
    input wire clk,
    input wire reset_n,
    input wire remote,
    input wire cmd_valid,
    input wire [4:0] cmd_code,
    input wire cmd_chan,
    input wire [15:0] cmd_wdata,
    input wire [1:0] pwr_valid,
    input wire [15:0] pwr_dbm_ch1,
    input wire [15:0] pwr_dbm_ch2,
    input wire [15:0] pwr_lin_ch1,
    input wire [15:0] pwr_lin_ch2,
    input wire [1:0] filter_full,
    output reg rsp_valid_r,
    output reg [31:0] rsp_data_r,
    output reg rsp_error_r,
    output reg [1:0] low_ind_r,
    output reg [1:0] high_ind_r,
    output reg rdg_valid_r,
    output reg [15:0] rdg_ch1_r,
    output reg [15:0] rdg_ch2_r,
    output reg [1:0] mode_r
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function limit_ok;
    input [15:0] v;
    begin
        limit_ok = ($signed(v) >= $signed(`PLAM_LIMIT_MIN)) && ($signed(v) <= $signed(`PLAM_LIMIT_MAX));
    end
endfunction

// Sum and difference on linear power; ratio as a dB difference of the log readings
function [31:0] plam_math;
    input [1:0] op;
    input [15:0] lin_a;
    input [15:0] lin_b;
    input [15:0] dbm_a;
    input [15:0] dbm_b;
    begin
        case (op)
            `PLAM_OP_SUM: plam_math = {16'h0000, lin_a} + {16'h0000, lin_b};
            `PLAM_OP_DIFFERENCE: plam_math = {16'h0000, lin_a} - {16'h0000, lin_b};
            `PLAM_OP_RATIO: plam_math = {{16{dbm_a[15]}}, dbm_a} - {{16{dbm_b[15]}}, dbm_b};
            default: plam_math = 32'h0000_0000;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Remote pin synchroniser

reg remote_m_r;
reg remote_s_r;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        remote_m_r <= 1'b0;
        remote_s_r <= 1'b0;
    end
    else
    begin
        remote_m_r <= remote;
        remote_s_r <= remote_m_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Latest readings per channel

reg [31:0] dbm_r;
reg [31:0] lin_r;
reg [1:0] seen_r;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        dbm_r <= 32'h0000_0000;
        lin_r <= 32'h0000_0000;
        seen_r <= 2'h0;
    end
    else
    begin
        if (pwr_valid[0])
        begin
            dbm_r[15:0] <= pwr_dbm_ch1;
            lin_r[15:0] <= pwr_lin_ch1;
        end
        // Channel two never reports on the single-channel variant
        if (pwr_valid[1] && (SINGLE_CH == 0))
        begin
            dbm_r[31:16] <= pwr_dbm_ch2;
            lin_r[31:16] <= pwr_lin_ch2;
        end
        seen_r <= seen_r | pwr_valid;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Alarm units

reg [31:0] lo_lim_r;
reg [31:0] up_lim_r;
reg [1:0] lo_en_r;
reg [1:0] up_en_r;
reg [1:0] clear_r;
wire [1:0] lo_act;
wire [1:0] up_act;
wire [1:0] lo_lat;
wire [1:0] up_lat;

plam_alarm u_alarm_ch1
(
    .clk(clk),
    .reset_n(reset_n),
    .seen(seen_r[0]),
    .level(dbm_r[15:0]),
    .low_limit(lo_lim_r[15:0]),
    .upp_limit(up_lim_r[15:0]),
    .low_en(lo_en_r[0]),
    .upp_en(up_en_r[0]),
    .clear(clear_r[0]),
    .lo_act_r(lo_act[0]),
    .up_act_r(up_act[0]),
    .lo_lat_r(lo_lat[0]),
    .up_lat_r(up_lat[0])
);

plam_alarm u_alarm_ch2
(
    .clk(clk),
    .reset_n(reset_n),
    .seen(seen_r[1]),
    .level(dbm_r[31:16]),
    .low_limit(lo_lim_r[31:16]),
    .upp_limit(up_lim_r[31:16]),
    .low_en(lo_en_r[1]),
    .upp_en(up_en_r[1]),
    .clear(clear_r[1]),
    .lo_act_r(lo_act[1]),
    .up_act_r(up_act[1]),
    .lo_lat_r(lo_lat[1]),
    .up_lat_r(up_lat[1])
);

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        low_ind_r <= 2'h0;
        high_ind_r <= 2'h0;
    end
    else
    begin
        low_ind_r <= lo_act; // [RULE_06]
        high_ind_r <= up_act; // [RULE_07]
    end
end

////////////////////////////////////////////////////////////////////////////////
// Command decode

reg opa_r;
reg opb_r;
reg [1:0] oper_r;
wire ch;
wire ch_bad;
wire [31:0] math_a;
wire [31:0] math_b;

assign ch = cmd_chan;
assign ch_bad = (SINGLE_CH != 0) && cmd_chan; // [RULE_22]
assign math_a = {lin_r[opa_r*16 +: 16], dbm_r[opa_r*16 +: 16]};
assign math_b = {lin_r[opb_r*16 +: 16], dbm_r[opb_r*16 +: 16]};

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        lo_lim_r <= {`PLAM_RST_LOW_LIMIT, `PLAM_RST_LOW_LIMIT};
        up_lim_r <= {`PLAM_RST_UPP_LIMIT, `PLAM_RST_UPP_LIMIT};
        lo_en_r <= 2'h0;
        up_en_r <= 2'h0;
        clear_r <= 2'h0;
        opa_r <= `PLAM_SRC_CH_ONE;
        opb_r <= `PLAM_SRC_CH_TWO;
        oper_r <= `PLAM_RST_OP;
        mode_r <= `PLAM_RST_MODE;
        rsp_valid_r <= 1'b0;
        rsp_data_r <= 32'h0000_0000;
        rsp_error_r <= 1'b0;
    end
    else
    begin
        clear_r <= 2'h0;
        rsp_valid_r <= cmd_valid;
        rsp_data_r <= 32'h0000_0000;
        rsp_error_r <= 1'b0;
        if (!remote_s_r)
        begin
            mode_r <= `PLAM_MODE_NORMAL; // [RULE_19] [RULE_20]
        end
        if (cmd_valid)
        begin
            if (ch_bad && (cmd_code <= `PLAM_CMD_CLEAR))
            begin
                rsp_error_r <= 1'b1; // [RULE_22]
            end
            else
            begin
                case (cmd_code)
                    `PLAM_CMD_FAIL_Q:
                    begin
                        rsp_data_r[`PLAM_FAIL_SUM] <= lo_act[ch] | up_act[ch] | lo_lat[ch] | up_lat[ch]; // [RULE_01]
                        rsp_data_r[`PLAM_FAIL_LO_ACT] <= lo_act[ch]; // [RULE_02] [RULE_03]
                        rsp_data_r[`PLAM_FAIL_UP_ACT] <= up_act[ch]; // [RULE_02]
                        rsp_data_r[`PLAM_FAIL_LO_LAT] <= lo_lat[ch]; // [RULE_02]
                        rsp_data_r[`PLAM_FAIL_UP_LAT] <= up_lat[ch]; // [RULE_02]
                    end
                    `PLAM_CMD_LOW_W:
                    begin
                        if (limit_ok(cmd_wdata))
                            lo_lim_r[ch*16 +: 16] <= cmd_wdata; // [RULE_05]
                        else
                            rsp_error_r <= 1'b1;
                    end
                    `PLAM_CMD_LOW_R:
                    begin
                        rsp_data_r <= {{16{lo_lim_r[ch*16+15]}}, lo_lim_r[ch*16 +: 16]}; // [RULE_05]
                    end
                    `PLAM_CMD_UPP_W:
                    begin
                        if (limit_ok(cmd_wdata))
                            up_lim_r[ch*16 +: 16] <= cmd_wdata; // [RULE_05]
                        else
                            rsp_error_r <= 1'b1;
                    end
                    `PLAM_CMD_UPP_R:
                    begin
                        rsp_data_r <= {{16{up_lim_r[ch*16+15]}}, up_lim_r[ch*16 +: 16]}; // [RULE_05]
                    end
                    `PLAM_CMD_LOEN_W:
                    begin
                        lo_en_r[ch] <= cmd_wdata[0]; // [RULE_08]
                    end
                    `PLAM_CMD_LOEN_R:
                    begin
                        rsp_data_r[0] <= lo_en_r[ch]; // [RULE_08]
                    end
                    `PLAM_CMD_UPEN_W:
                    begin
                        up_en_r[ch] <= cmd_wdata[0]; // [RULE_09]
                    end
                    `PLAM_CMD_UPEN_R:
                    begin
                        rsp_data_r[0] <= up_en_r[ch]; // [RULE_09]
                    end
                    `PLAM_CMD_BOTH_W:
                    begin
                        lo_en_r[ch] <= cmd_wdata[0]; // [RULE_10]
                        up_en_r[ch] <= cmd_wdata[0]; // [RULE_10]
                    end
                    `PLAM_CMD_BOTH_R:
                    begin
                        rsp_data_r[0] <= lo_en_r[ch] | up_en_r[ch]; // [RULE_11]
                        // A half-enabled channel becomes fully enabled by the query
                        if (lo_en_r[ch] | up_en_r[ch])
                        begin
                            lo_en_r[ch] <= 1'b1; // [RULE_12]
                            up_en_r[ch] <= 1'b1; // [RULE_12]
                        end
                    end
                    `PLAM_CMD_CLEAR:
                    begin
                        clear_r[ch] <= 1'b1; // [RULE_21]
                    end
                    `PLAM_CMD_OPA_W:
                    begin
                        if (cmd_wdata[0] && (SINGLE_CH != 0))
                            rsp_error_r <= 1'b1;
                        else
                            opa_r <= cmd_wdata[0]; // [RULE_13]
                    end
                    `PLAM_CMD_OPA_R:
                    begin
                        rsp_data_r[0] <= opa_r; // [RULE_13]
                    end
                    `PLAM_CMD_OPB_W:
                    begin
                        if (cmd_wdata[0] && (SINGLE_CH != 0))
                            rsp_error_r <= 1'b1;
                        else
                            opb_r <= cmd_wdata[0]; // [RULE_13]
                    end
                    `PLAM_CMD_OPB_R:
                    begin
                        rsp_data_r[0] <= opb_r; // [RULE_13]
                    end
                    `PLAM_CMD_OPER_W:
                    begin
                        if (cmd_wdata > {14'h0000, `PLAM_OP_RATIO})
                            rsp_error_r <= 1'b1;
                        else
                            oper_r <= cmd_wdata[1:0]; // [RULE_14]
                    end
                    `PLAM_CMD_OPER_R:
                    begin
                        rsp_data_r[1:0] <= oper_r; // [RULE_14]
                    end
                    `PLAM_CMD_MATH_Q:
                    begin
                        rsp_data_r <= plam_math(oper_r, math_a[31:16], math_b[31:16],
                                                math_a[15:0], math_b[15:0]); // [RULE_15]
                    end
                    `PLAM_CMD_MODE_W:
                    begin
                        // Modes only exist under bus control
                        if (!remote_s_r || (cmd_wdata > {14'h0000, `PLAM_MODE_FILTER}))
                            rsp_error_r <= 1'b1; // [RULE_19]
                        else
                            mode_r <= cmd_wdata[1:0];
                    end
                    `PLAM_CMD_MODE_R:
                    begin
                        rsp_data_r[1:0] <= mode_r;
                    end
                    default:
                    begin
                        rsp_error_r <= 1'b1;
                    end
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Reading pacing

reg [23:0] pace_r;
reg [23:0] pace_nxt;
reg emit_nxt;

always @*
begin
    pace_nxt = pace_r;
    emit_nxt = 1'b0;
    case (mode_r)
        `PLAM_MODE_FILTER:
        begin
            // Withheld until channel one's averaging filter is full
            pace_nxt = 24'h00_0000;
            emit_nxt = pwr_valid[0] && filter_full[0]; // [RULE_18]
        end
        `PLAM_MODE_FAST:
        begin
            if (pace_r == 24'h00_0000)
            begin
                pace_nxt = FAST_CYC - 24'h00_0001; // [RULE_17]
                emit_nxt = seen_r[0];
            end
            else if (pace_r >= FAST_CYC)
                pace_nxt = FAST_CYC - 24'h00_0001;
            else
                pace_nxt = pace_r - 24'h00_0001;
        end
        default:
        begin
            if (pace_r == 24'h00_0000)
            begin
                pace_nxt = NORMAL_CYC - 24'h00_0001; // [RULE_16]
                emit_nxt = seen_r[0];
            end
            else
                pace_nxt = pace_r - 24'h00_0001;
        end
    endcase
end

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        pace_r <= 24'h00_0000;
        rdg_valid_r <= 1'b0;
        rdg_ch1_r <= 16'h0000;
        rdg_ch2_r <= 16'h0000;
    end
    else
    begin
        pace_r <= pace_nxt;
        rdg_valid_r <= emit_nxt;
        if (emit_nxt)
        begin
            rdg_ch1_r <= (mode_r == `PLAM_MODE_FILTER) ? pwr_dbm_ch1 : dbm_r[15:0];
            rdg_ch2_r <= dbm_r[31:16];
        end
    end
end

endmodule

`default_nettype wire

// ---- logic/plam_regs.vh ----
`ifndef PLAM_REGS_VH
`define PLAM_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Command codes
`define PLAM_CMD_FAIL_Q 5'h00
`define PLAM_CMD_LOW_W 5'h01
`define PLAM_CMD_LOW_R 5'h02
`define PLAM_CMD_UPP_W 5'h03
`define PLAM_CMD_UPP_R 5'h04
`define PLAM_CMD_LOEN_W 5'h05
`define PLAM_CMD_LOEN_R 5'h06
`define PLAM_CMD_UPEN_W 5'h07
`define PLAM_CMD_UPEN_R 5'h08
`define PLAM_CMD_BOTH_W 5'h09
`define PLAM_CMD_BOTH_R 5'h0A
`define PLAM_CMD_CLEAR 5'h0B
`define PLAM_CMD_OPA_W 5'h0C
`define PLAM_CMD_OPA_R 5'h0D
`define PLAM_CMD_OPB_W 5'h0E
`define PLAM_CMD_OPB_R 5'h0F
`define PLAM_CMD_OPER_W 5'h10
`define PLAM_CMD_OPER_R 5'h11
`define PLAM_CMD_MATH_Q 5'h12
`define PLAM_CMD_MODE_W 5'h13
`define PLAM_CMD_MODE_R 5'h14

////////////////////////////////////////////////////////////////////////////////
// Alarm flag word field positions
`define PLAM_FAIL_SUM 4
`define PLAM_FAIL_LO_ACT 3
`define PLAM_FAIL_UP_ACT 2
`define PLAM_FAIL_LO_LAT 1
`define PLAM_FAIL_UP_LAT 0

////////////////////////////////////////////////////////////////////////////////
// Encodings and reset values
`define PLAM_OP_SUM 2'h0
`define PLAM_OP_DIFFERENCE 2'h1
`define PLAM_OP_RATIO 2'h2
`define PLAM_SRC_CH_ONE 1'h0
`define PLAM_SRC_CH_TWO 1'h1
`define PLAM_MODE_NORMAL 2'h0
`define PLAM_MODE_FAST 2'h1
`define PLAM_MODE_FILTER 2'h2
`define PLAM_LIMIT_MIN 16'hD8F1
`define PLAM_LIMIT_MAX 16'h270F
`define PLAM_RST_LOW_LIMIT 16'hD8F1
`define PLAM_RST_UPP_LIMIT 16'h270F
`define PLAM_RST_OP `PLAM_OP_SUM
`define PLAM_RST_MODE `PLAM_MODE_NORMAL

////////////////////////////////////////////////////////////////////////////////
// Timing
`define PLAM_CLK_KHZ 40000
`define PLAM_NORMAL_MS 50
`define PLAM_FAST_MS 4
`define PLAM_NORMAL_CYC (`PLAM_NORMAL_MS * `PLAM_CLK_KHZ)
`define PLAM_FAST_CYC (`PLAM_FAST_MS * `PLAM_CLK_KHZ)

`endif

// ---- verif/plam_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "plam_regs.vh"
module plam_core_props
#(
    parameter NORMAL_CYC = 20,
    parameter FAST_CYC = 8
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic remote,
    input wire logic cmd_valid,
    input wire logic [4:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [1:0] pwr_valid,
    input wire logic [15:0] pwr_dbm_ch1,
    input wire logic [1:0] filter_full,
    input wire logic rsp_valid_r,
    input wire logic [31:0] rsp_data_r,
    input wire logic rsp_error_r,
    input wire logic [1:0] low_ind_r,
    input wire logic rdg_valid_r,
    input wire logic [15:0] rdg_ch1_r,
    input wire logic [1:0] mode_r
);
    localparam int NGAP = NORMAL_CYC;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_fast;
        rdg_valid_r && mode_r == `PLAM_MODE_FAST;
    endsequence
    sequence s_norm;
        rdg_valid_r && mode_r == `PLAM_MODE_NORMAL;
    endsequence
    property p_rsp;
        1'h1 |=> rsp_valid_r == $past(cmd_valid);
    endproperty
    property p_fail_sum;
        cmd_valid && cmd_code == `PLAM_CMD_FAIL_Q |=> rsp_data_r[4] == (|rsp_data_r[3:0]) && rsp_data_r[31:5] == 0;
    endproperty
    property p_lim_range;
        cmd_valid && cmd_code == `PLAM_CMD_LOW_W && ($signed(cmd_wdata) > 16'sh270F || $signed(cmd_wdata) < -16'sh270F)
            |=> rsp_error_r;
    endproperty
    property p_oper_bad;
        cmd_valid && cmd_code == `PLAM_CMD_OPER_W && cmd_wdata > 16'h0002 |=> rsp_error_r;
    endproperty
    property p_mode_local;
        cmd_valid && cmd_code == `PLAM_CMD_MODE_W && !remote && !$past(remote) && !$past(remote, 2) && !$past(remote, 3)
            |=> rsp_error_r;
    endproperty
    property p_local_normal;
        !remote [*5] |-> mode_r == `PLAM_MODE_NORMAL;
    endproperty
    // Indicator lags its cause by three edges
    property p_ind_quiet;
        (!cmd_valid && !pwr_valid[0]) [*5] |-> $stable(low_ind_r[0]);
    endproperty
    // Bench runs FAST_CYC at 8
    property p_fast;
        s_fast |=> (!rdg_valid_r || mode_r != `PLAM_MODE_FAST) [*7] ##1 (rdg_valid_r || mode_r != `PLAM_MODE_FAST);
    endproperty
    property p_normal;
        s_norm |-> ##[1:NGAP] (rdg_valid_r || mode_r != `PLAM_MODE_NORMAL);
    endproperty
    property p_filter;
        mode_r == `PLAM_MODE_FILTER && pwr_valid[0] && filter_full[0] |=> rdg_valid_r && rdg_ch1_r == $past(pwr_dbm_ch1);
    endproperty
    a_rsp: assert property (p_rsp) else $error("late answer");
    a_fail_sum: assert property (p_fail_sum) else $error("bad summary");
    a_lim_range: assert property (p_lim_range) else $error("limit range");
    a_oper_bad: assert property (p_oper_bad) else $error("bad operator");
    a_mode_local: assert property (p_mode_local) else $error("mode set in local");
    a_local_normal: assert property (p_local_normal) else $error("mode not normal in local");
    a_ind_quiet: assert property (p_ind_quiet) else $error("stray indicator");
    a_fast: assert property (p_fast) else $error("fast spacing");
    a_normal: assert property (p_normal) else $error("normal reading late");
    a_filter: assert property (p_filter) else $error("filter_full_mode miss");
endmodule
bind plam_core plam_core_props #(.NORMAL_CYC(NORMAL_CYC), .FAST_CYC(FAST_CYC)) i_plam_core_props
(
    .clk(clk), .reset_n(reset_n), .remote(remote), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .pwr_valid(pwr_valid), .pwr_dbm_ch1(pwr_dbm_ch1), .filter_full(filter_full),
    .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .rsp_error_r(rsp_error_r), .low_ind_r(low_ind_r),
    .rdg_valid_r(rdg_valid_r), .rdg_ch1_r(rdg_ch1_r), .mode_r(mode_r)
);
`default_nettype wire

// ---- verif/plam_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module plam_host_model
(
    input wire logic clk,
    output logic cmd_valid,
    output logic [4:0] cmd_code,
    output logic cmd_chan,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid_r,
    input wire logic [31:0] rsp_data_r,
    input wire logic rsp_error_r
);
    initial
    begin
        cmd_valid = 1'h0;
    end
    // Answer stands just after the taking edge and is read 1 ns later
    task automatic send(input [4:0] c, input ch, input [15:0] w, output [31:0] d, output e);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_code <= c;
        cmd_chan <= ch;
        cmd_wdata <= w;
        @(posedge clk);
        cmd_valid <= 1'h0;
        #1;
        d = (rsp_valid_r === 1'h1) ? rsp_data_r : 32'hxxxx_xxxx;
        e = (rsp_valid_r === 1'h1) ? rsp_error_r : 1'hx;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_plam_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "plam_regs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_plam_core;
    logic clk, reset_n, remote, cmd_valid, cmd_chan;
    logic [4:0] cmd_code;
    logic [15:0] cmd_wdata, pwr_dbm_ch1, pwr_dbm_ch2, pwr_lin_ch1, pwr_lin_ch2, rdg_ch1_r, rdg_ch2_r;
    logic [1:0] pwr_valid, filter_full, low_ind_r, high_ind_r, mode_r;
    logic rsp_valid_r, rsp_error_r, rdg_valid_r;
    logic [31:0] rsp_data_r;
    logic [31:0] mexp [3] = '{32'h0000_0514, 32'h0000_02BC, 32'h0000_0046};
    int fail_count = 0, n_checks = 0, cyc = 0, n, i;
    plam_core #(.NORMAL_CYC(24'h00_0014), .FAST_CYC(24'h00_0008)) i_plam_core
    (
        .clk(clk), .reset_n(reset_n), .remote(remote), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_chan(cmd_chan), .cmd_wdata(cmd_wdata), .pwr_valid(pwr_valid), .pwr_dbm_ch1(pwr_dbm_ch1),
        .pwr_dbm_ch2(pwr_dbm_ch2), .pwr_lin_ch1(pwr_lin_ch1), .pwr_lin_ch2(pwr_lin_ch2),
        .filter_full(filter_full), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
        .rsp_error_r(rsp_error_r), .low_ind_r(low_ind_r), .high_ind_r(high_ind_r), .rdg_valid_r(rdg_valid_r),
        .rdg_ch1_r(rdg_ch1_r), .rdg_ch2_r(rdg_ch2_r), .mode_r(mode_r)
    );
    plam_host_model i_plam_host_model
    (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_chan(cmd_chan), .cmd_wdata(cmd_wdata),
        .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .rsp_error_r(rsp_error_r)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input [4:0] c, input ch, input [31:0] e, input string nm);
        logic [31:0] d;
        logic er;
        i_plam_host_model.send(c, ch, 16'h0000, d, er);
        `CHK(nm, e, d)
    endtask
    task automatic wr(input [4:0] c, input ch, input [15:0] w, input er_e);
        logic [31:0] d;
        logic er;
        i_plam_host_model.send(c, ch, w, d, er);
        `CHK("error flag", er_e, er)
    endtask
    // Strobe, then wait for indicators
    task automatic pwr(input [1:0] v, input [15:0] d1, input [15:0] d2);
        @(posedge clk);
        pwr_valid <= v;
        pwr_dbm_ch1 <= d1;
        pwr_dbm_ch2 <= d2;
        @(posedge clk);
        pwr_valid <= 2'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic gap(output int g);
        while (rdg_valid_r !== 1'h1) tick();
        tick();
        for (g = 1; g < 60 && rdg_valid_r !== 1'h1; g++) tick();
    endtask
    task automatic cnt(input int c, output int g);
        g = 0;
        repeat (c)
        begin
            tick();
            if (rdg_valid_r === 1'h1) g++;
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // Run needs under 1000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        reset_n = 1'h0;
        remote = 1'h1;
        pwr_valid = 2'h0;
        pwr_dbm_ch1 = 16'h0000;
        pwr_dbm_ch2 = 16'h0000;
        pwr_lin_ch1 = 16'h03E8;
        pwr_lin_ch2 = 16'h012C;
        filter_full = 2'h0;
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        rd(`PLAM_CMD_LOW_R, 1'h1, 32'hFFFF_D8F1, "low limit");
        rd(`PLAM_CMD_UPP_R, 1'h1, 32'h0000_270F, "upper limit");
        rd(`PLAM_CMD_LOEN_R, 1'h1, 32'h0000_0000, "low enable");
        rd(`PLAM_CMD_UPEN_R, 1'h1, 32'h0000_0000, "upper enable");
        rd(`PLAM_CMD_OPB_R, 1'h0, 32'h0000_0001, "operand two");
        rd(`PLAM_CMD_MODE_R, 1'h0, 32'h0000_0000, "mode");
        wr(`PLAM_CMD_LOW_W, 1'h0, 16'hD8F0, 1'h1);
        wr(`PLAM_CMD_UPP_W, 1'h0, 16'h2710, 1'h1);
        wr(`PLAM_CMD_LOW_W, 1'h0, 16'h0064, 1'h0);
        wr(`PLAM_CMD_UPP_W, 1'h0, 16'h00C8, 1'h0);
        rd(`PLAM_CMD_LOW_R, 1'h0, 32'h0000_0064, "low limit");
        rd(`PLAM_CMD_UPP_R, 1'h0, 32'h0000_00C8, "upper limit");
        wr(`PLAM_CMD_LOEN_W, 1'h0, 16'h0001, 1'h0);
        pwr(2'h1, 16'h0032, 16'h0000);
        rd(`PLAM_CMD_FAIL_Q, 1'h0, 32'h0000_001A, "flags");
        `CHK("low indicator", 1'h1, low_ind_r[0])
        rd(`PLAM_CMD_FAIL_Q, 1'h1, 32'h0000_0000, "ch2 flags");
        pwr(2'h1, 16'h012C, 16'h0000);
        rd(`PLAM_CMD_FAIL_Q, 1'h0, 32'h0000_0012, "flags");
        `CHK("indicators", 4'h0, {low_ind_r, high_ind_r})
        wr(`PLAM_CMD_CLEAR, 1'h0, 16'h0000, 1'h0);
        rd(`PLAM_CMD_FAIL_Q, 1'h0, 32'h0000_0000, "flags");
        wr(`PLAM_CMD_UPEN_W, 1'h0, 16'h0001, 1'h0);
        rd(`PLAM_CMD_FAIL_Q, 1'h0, 32'h0000_0015, "flags");
        `CHK("high indicator", 1'h1, high_ind_r[0])
        pwr(2'h1, 16'h0096, 16'h0000);
        rd(`PLAM_CMD_FAIL_Q, 1'h0, 32'h0000_0011, "flags");
        wr(`PLAM_CMD_BOTH_W, 1'h0, 16'h0000, 1'h0);
        rd(`PLAM_CMD_LOEN_R, 1'h0, 32'h0000_0000, "low enable");
        rd(`PLAM_CMD_BOTH_R, 1'h0, 32'h0000_0000, "both enable");
        wr(`PLAM_CMD_LOEN_W, 1'h0, 16'h0001, 1'h0);
        rd(`PLAM_CMD_UPEN_R, 1'h0, 32'h0000_0000, "upper enable");
        rd(`PLAM_CMD_BOTH_R, 1'h0, 32'h0000_0001, "both enable");
        rd(`PLAM_CMD_UPEN_R, 1'h0, 32'h0000_0001, "upper enable");
        pwr(2'h3, 16'h0032, 16'hFFEC);
        for (i = 0; i < 3; i++)
        begin
            wr(`PLAM_CMD_OPER_W, 1'h0, i[15:0], 1'h0);
            rd(`PLAM_CMD_OPER_R, 1'h0, i, "operator");
            rd(`PLAM_CMD_MATH_Q, 1'h0, mexp[i], "math result");
        end
        wr(`PLAM_CMD_OPER_W, 1'h0, 16'h0003, 1'h1);
        wr(`PLAM_CMD_OPA_W, 1'h0, 16'h0001, 1'h0);
        wr(`PLAM_CMD_OPB_W, 1'h0, 16'h0000, 1'h0);
        rd(`PLAM_CMD_OPA_R, 1'h0, 32'h0000_0001, "operand one");
        wr(`PLAM_CMD_OPER_W, 1'h0, 16'h0001, 1'h0);
        rd(`PLAM_CMD_MATH_Q, 1'h0, 32'hFFFF_FD44, "swapped diff");
        gap(n);
        `CHK("normal spacing", 20, n)
        wr(`PLAM_CMD_MODE_W, 1'h0, 16'h0001, 1'h0);
        gap(n);
        `CHK("fast spacing", 8, n)
        wr(`PLAM_CMD_MODE_W, 1'h0, 16'h0002, 1'h0);
        pwr(2'h1, 16'h0055, 16'h0000);
        cnt(30, n);
        `CHK("filter_full_mode strobes", 0, n)
        filter_full <= 2'h1;
        pwr(2'h1, 16'h0077, 16'h0000);
        `CHK("filter_full_mode reading", 16'h0077, rdg_ch1_r)
        wr(`PLAM_CMD_MODE_W, 1'h0, 16'h0003, 1'h1);
        @(posedge clk);
        remote <= 1'h0;
        cnt(6, n);
        `CHK("local mode", `PLAM_MODE_NORMAL, mode_r)
        wr(`PLAM_CMD_MODE_W, 1'h0, 16'h0001, 1'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
